// ---- shared/conv_ctrl_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the conversion control block
`ifndef CONV_CTRL_CFG_SVH
`define CONV_CTRL_CFG_SVH

// ==========================================================
// Register byte offsets on the APB bus
`define OFS_SC1 12'h000
`define OFS_SC2 12'h004
`define OFS_CFG 12'h008
`define OFS_CVH 12'h00C
`define OFS_CVL 12'h010
`define OFS_RH 12'h014
`define OFS_RL 12'h018
`define OFS_PWR 12'h01C

// ==========================================================
// Field positions
`define SC1_DONE 7
`define SC1_IEN 6
`define SC1_CONT 5
`define SC2_ACTIVE 7
`define SC2_HWTRG 6
`define SC2_CMPEN 5
`define SC2_CMPGT 4
`define CFG_LPC 7
`define CFG_LSMP 4
`define PWR_WAIT 0
`define PWR_STOP 1

// ==========================================================
// Reset values and field codes
`define SC1_RST 8'h1F
`define CFG_RST 8'h00
`define CH_OFF 5'h1F
`define CLK_ASYNC 2'h3
`define MODE_10BIT 2'h2

// ==========================================================
// Timing: converter clock counts and the async start-up time
`define SAMPLE_SHORT 8'h03
`define SAMPLE_LONG 8'h17
`define APPROX_8 8'h0B
`define APPROX_10 8'h0E
`define FIRST_SETUP 8'h08 // 5 bus cycles plus 3 converter cycles ahead of sampling
`define ASYNC_START_US 5
`define CLK_MHZ 100
`define ASYNC_START_CYC ((`ASYNC_START_US * `CLK_MHZ) - 1)

`endif

// ---- shared/conv_ctrl_pkg.sv ----
// Types shared by the conversion control block
package conv_ctrl_pkg;
    // Conversion sequencer states, Gray along idle-start-sample-approx-transfer
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_SAMPLE = 3'h3,
        ST_APPROX = 3'h2,
        ST_XFER = 3'h6
    } conv_state_e;

    // APB request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // APB answer bundle
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // Analog front end handshake
    typedef struct packed {
        logic [4:0] channel;
        logic sample_en;
        logic approx_en;
        logic async_clk_en;
        logic low_power;
    } afe_ctrl_s;
endpackage : conv_ctrl_pkg

// ---- core/adc_conversion_control.sv ----
// Conversion sequencing, compare and result transfer for the ADC, APB slave
`timescale 1ns/1ns
`include "conv_ctrl_cfg.svh"
module adc_conversion_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire conv_ctrl_pkg::apb_req_s apb_req,
    output conv_ctrl_pkg::apb_rsp_s apb_rsp,
    input wire logic hw_trigger_input,
    input wire logic [9:0] afe_result,
    output conv_ctrl_pkg::afe_ctrl_s afe_ctrl,
    output logic conv_irq,
    output logic converter_active
);
    import conv_ctrl_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0] status_control_one_reg_r;
    logic [7:0] status_control_two_reg_r;
    logic [7:0] converter_config_reg_r;
    logic [7:0] compare_value_high_r;
    logic [7:0] compare_value_low_r;
    logic [7:0] result_high_byte_r;
    logic [7:0] result_low_byte_r;
    logic [1:0] power_mode_r;
    logic block_r;
    conv_state_e state_r;
    logic [8:0] count_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_d_r;
    apb_rsp_s apb_rsp_r;
    afe_ctrl_s afe_ctrl_r;
    logic irq_r;
    logic active_r;

    // ==========================================================
    // Decode and field views
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [4:0] channel_select;
    logic conversion_done_flag;
    logic done_irq_enable;
    logic continuous_enable;
    logic trigger_source_select;
    logic compare_enable;
    logic compare_direction;
    logic long_sample_select;
    logic low_power_select;
    logic [1:0] input_clock_select;
    logic [1:0] mode_sel;
    logic ten_bit;
    logic stop_mode;

    // Write or read takes effect in the access phase
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    assign channel_select = status_control_one_reg_r[4:0];
    assign conversion_done_flag = status_control_one_reg_r[`SC1_DONE];
    assign done_irq_enable = status_control_one_reg_r[`SC1_IEN];
    assign continuous_enable = status_control_one_reg_r[`SC1_CONT];
    assign trigger_source_select = status_control_two_reg_r[`SC2_HWTRG];
    assign compare_enable = status_control_two_reg_r[`SC2_CMPEN];
    assign compare_direction = status_control_two_reg_r[`SC2_CMPGT];
    assign long_sample_select = converter_config_reg_r[`CFG_LSMP];
    assign low_power_select = converter_config_reg_r[`CFG_LPC];
    assign input_clock_select = converter_config_reg_r[1:0];
    assign mode_sel = converter_config_reg_r[3:2];
    assign ten_bit = (mode_sel == `MODE_10BIT);
    assign stop_mode = power_mode_r[`PWR_STOP];

    // Address match helper, used by every decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // ==========================================================
    // Abort and start conditions
    logic wr_sc1;
    logic wr_other;
    logic stop_abort;
    logic trig_edge;
    logic sw_start;
    logic hw_start;
    logic busy;

    assign wr_sc1 = wr_en & hit(apb_req.paddr, `OFS_SC1);
    assign wr_other = wr_en & (hit(apb_req.paddr, `OFS_SC2) | hit(apb_req.paddr, `OFS_CFG)
        | hit(apb_req.paddr, `OFS_CVH) | hit(apb_req.paddr, `OFS_CVL));
    assign stop_abort = (stop_mode | (wr_en & hit(apb_req.paddr, `OFS_PWR)
        & apb_req.pwdata[`PWR_STOP])) & (input_clock_select != `CLK_ASYNC);
    assign busy = (state_r != ST_IDLE);
    // Edge taken on the synchronised copies only
    assign trig_edge = trig_s2_r & ~trig_d_r;
    assign sw_start = wr_sc1 & ~trigger_source_select
        & (apb_req.pwdata[4:0] != `CH_OFF);
    // Ignored while busy; the channel must be on
    assign hw_start = trig_edge & trigger_source_select & ~busy
        & (channel_select != `CH_OFF);
    assign mapped = hit(apb_req.paddr, `OFS_SC1) | hit(apb_req.paddr, `OFS_SC2)
        | hit(apb_req.paddr, `OFS_CFG) | hit(apb_req.paddr, `OFS_CVH)
        | hit(apb_req.paddr, `OFS_CVL) | hit(apb_req.paddr, `OFS_RH)
        | hit(apb_req.paddr, `OFS_RL) | hit(apb_req.paddr, `OFS_PWR);

    // ==========================================================
    // Compare and completion decision
    logic [9:0] cmp_value;
    logic [10:0] diff;
    logic cmp_true;
    logic blocked;
    logic do_xfer;
    logic [9:0] raw_res;

    assign raw_res = ten_bit ? afe_result : {2'h0, afe_result[9:2]};
    assign cmp_value = ten_bit ? {compare_value_high_r[1:0], compare_value_low_r}
        : {2'h0, compare_value_low_r};
    // Result plus two's complement of compare value
    assign diff = {1'b0, raw_res} + {1'b0, ~cmp_value} + 11'h001;
    // Carry out set means result >= compare value
    assign cmp_true = compare_direction ? diff[10] : ~diff[10];
    assign blocked = block_r & ten_bit;
    assign do_xfer = (state_r == ST_XFER) & ~blocked & (~compare_enable | cmp_true);

    // Whether the sequencer restarts after this finish
    logic restart;
    always_comb begin
        restart = 1'b0;
        if (state_r == ST_XFER) begin
            if (blocked && !(compare_enable && !cmp_true && !continuous_enable)) begin
                restart = 1'b1;
            end else if (continuous_enable) begin
                restart = 1'b1;
            end
        end
    end

    // ==========================================================
    // Trigger pin synchroniser, two flops before any logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            trig_s1_r <= hw_trigger_input;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end

    // ==========================================================
    // Conversion sequencer
    // Counts stand in for the analog timing; the bus clock is the converter clock here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            count_r <= 9'h000;
        end else if (wr_sc1 || wr_other || stop_abort) begin
            // Abort, and a control-one write may relaunch at once
            state_r <= sw_start ? ST_START : ST_IDLE;
            count_r <= (input_clock_select == `CLK_ASYNC) ? 9'(`ASYNC_START_CYC)
                : 9'({1'b0, `FIRST_SETUP} - 9'h001);
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // Waits for a start; also the hardware path in wait mode
                    if (hw_start) begin
                        state_r <= ST_START;
                        count_r <= (input_clock_select == `CLK_ASYNC)
                            ? 9'(`ASYNC_START_CYC)
                            : 9'({1'b0, `FIRST_SETUP} - 9'h001);
                    end
                end
                ST_START: begin
                    if (count_r == 9'h000) begin
                        state_r <= ST_SAMPLE;
                        count_r <= long_sample_select ? {1'b0, `SAMPLE_LONG}
                            : {1'b0, `SAMPLE_SHORT};
                    end else begin
                        count_r <= count_r - 9'h001;
                    end
                end
                ST_SAMPLE: begin
                    if (count_r == 9'h000) begin
                        state_r <= ST_APPROX;
                        count_r <= ten_bit ? {1'b0, `APPROX_10} : {1'b0, `APPROX_8};
                    end else begin
                        count_r <= count_r - 9'h001;
                    end
                end
                ST_APPROX: begin
                    if (count_r == 9'h000) begin
                        state_r <= ST_XFER;
                    end else begin
                        count_r <= count_r - 9'h001;
                    end
                end
                ST_XFER: begin
                    // Later continuous runs skip the start overhead
                    if (restart) begin
                        state_r <= ST_SAMPLE;
                        count_r <= long_sample_select ? {1'b0, `SAMPLE_LONG}
                            : {1'b0, `SAMPLE_SHORT};
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Result registers, done flag and split-read block
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_high_byte_r <= 8'h00;
            result_low_byte_r <= 8'h00;
        end else if (do_xfer) begin
            // An abort before the transfer cycle never reaches here, so old results stay
            result_high_byte_r <= ten_bit
                ? {6'h00, compare_enable ? diff[9:8] : raw_res[9:8]} : 8'h00;
            result_low_byte_r <= compare_enable ? diff[7:0] : raw_res[7:0];
        end
    end

    // Blocking arms on a high-byte read, ends only on a low-byte read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            block_r <= 1'b0;
        end else if (rd_en && hit(apb_req.paddr, `OFS_RL)) begin
            block_r <= 1'b0;
        end else if (rd_en && hit(apb_req.paddr, `OFS_RH)) begin
            block_r <= 1'b1;
        end
    end

    // Control one; the done flag set wins over the write that clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_control_one_reg_r <= `SC1_RST;
        end else begin
            if (wr_sc1) begin
                status_control_one_reg_r[6:0] <= apb_req.pwdata[6:0];
            end
            if (do_xfer) begin
                status_control_one_reg_r[`SC1_DONE] <= 1'b1;
            end else if (wr_sc1 || (rd_en && hit(apb_req.paddr, `OFS_RL))) begin
                status_control_one_reg_r[`SC1_DONE] <= 1'b0;
            end
        end
    end

    // Remaining writable registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_control_two_reg_r <= 8'h00;
            converter_config_reg_r <= `CFG_RST;
            compare_value_high_r <= 8'h00;
            compare_value_low_r <= 8'h00;
            power_mode_r <= 2'h0;
        end else if (wr_en) begin
            if (hit(apb_req.paddr, `OFS_SC2)) status_control_two_reg_r <= {1'b0, apb_req.pwdata[6:4], 4'h0};
            if (hit(apb_req.paddr, `OFS_CFG)) converter_config_reg_r <= apb_req.pwdata[7:0];
            if (hit(apb_req.paddr, `OFS_CVH)) compare_value_high_r <= {6'h00, apb_req.pwdata[1:0]};
            if (hit(apb_req.paddr, `OFS_CVL)) compare_value_low_r <= apb_req.pwdata[7:0];
            if (hit(apb_req.paddr, `OFS_PWR)) power_mode_r <= apb_req.pwdata[1:0];
        end
    end

    // ==========================================================
    // APB answer, no wait state: pready in the first access cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            apb_rsp_r <= '0;
        end else begin
            apb_rsp_r.pready <= apb_req.psel & ~apb_req.penable;
            apb_rsp_r.pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
            apb_rsp_r.prdata <= 32'h0000_0000;
            if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
                unique case (1'b1)
                    hit(apb_req.paddr, `OFS_SC1): apb_rsp_r.prdata <= {24'h0, status_control_one_reg_r};
                    hit(apb_req.paddr, `OFS_SC2): apb_rsp_r.prdata <= {24'h0, busy,
                        status_control_two_reg_r[6:0]};
                    hit(apb_req.paddr, `OFS_CFG): apb_rsp_r.prdata <= {24'h0, converter_config_reg_r};
                    hit(apb_req.paddr, `OFS_CVH): apb_rsp_r.prdata <= {24'h0, compare_value_high_r};
                    hit(apb_req.paddr, `OFS_CVL): apb_rsp_r.prdata <= {24'h0, compare_value_low_r};
                    hit(apb_req.paddr, `OFS_RH): apb_rsp_r.prdata <= {24'h0, result_high_byte_r};
                    hit(apb_req.paddr, `OFS_RL): apb_rsp_r.prdata <= {24'h0, result_low_byte_r};
                    hit(apb_req.paddr, `OFS_PWR): apb_rsp_r.prdata <= {30'h0, power_mode_r};
                    default: apb_rsp_r.prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Analog front end controls, interrupt and activity flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            afe_ctrl_r <= '0;
            irq_r <= 1'b0;
            active_r <= 1'b0;
        end else begin
            afe_ctrl_r.channel <= channel_select;
            afe_ctrl_r.sample_en <= (state_r == ST_SAMPLE);
            afe_ctrl_r.approx_en <= (state_r == ST_APPROX);
            // Async generator only powered while converting
            afe_ctrl_r.async_clk_en <= busy & (input_clock_select == `CLK_ASYNC);
            afe_ctrl_r.low_power <= low_power_select;
            irq_r <= conversion_done_flag & done_irq_enable;
            active_r <= busy;
        end
    end

    assign apb_rsp = apb_rsp_r;
    assign afe_ctrl = afe_ctrl_r;
    assign conv_irq = irq_r;
    assign converter_active = active_r;
endmodule : adc_conversion_control

// ---- sim/conv_ctrl_props.sv ----
// Port-level assertions for the conversion control block
`timescale 1ns/1ns
`include "conv_ctrl_cfg.svh"
module conv_ctrl_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire conv_ctrl_pkg::apb_req_s apb_req,
    input wire conv_ctrl_pkg::apb_rsp_s apb_rsp,
    input wire logic hw_trigger_input,
    input wire logic [9:0] afe_result,
    input wire conv_ctrl_pkg::afe_ctrl_s afe_ctrl,
    input wire logic conv_irq,
    input wire logic converter_active
);
    import conv_ctrl_pkg::*;
    logic wr;
    logic [11:0] adr;
    logic [7:0] wd;
    logic hwt_r;
    logic ien_r;
    logic stop_r;
    logic [1:0] csel_r;
    logic [7:0] samp_r;
    logic [7:0] appr_r;
    // =============================================
    // Shadow of control bits
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign adr = apb_req.paddr;
    assign wd = apb_req.pwdata[7:0];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {hwt_r, ien_r, stop_r, csel_r} <= 5'h00;
        end else if (wr) begin
            if (adr == `OFS_SC1) ien_r <= wd[`SC1_IEN];
            if (adr == `OFS_SC2) hwt_r <= wd[`SC2_HWTRG];
            if (adr == `OFS_PWR) stop_r <= wd[`PWR_STOP];
            if (adr == `OFS_CFG) csel_r <= wd[1:0];
        end
    end
    // Run lengths; a repetition would be too long to unroll
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_r <= 8'h00;
            appr_r <= 8'h00;
        end else begin
            samp_r <= afe_ctrl.sample_en ? samp_r + 8'h01 : 8'h00;
            appr_r <= afe_ctrl.approx_en ? appr_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // =============================================
    // Properties
    property p_sw_start;
        wr && adr == `OFS_SC1 && wd[4:0] != `CH_OFF && !hwt_r && !stop_r
            |-> ##[1:3] converter_active;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("no start after write");
    property p_ch_off;
        wr && adr == `OFS_SC1 && wd[4:0] == `CH_OFF |-> ##[1:3] (!converter_active [*3]);
    endproperty
    a_ch_off: assert property (p_ch_off) else $error("active with channel off");
    property p_abort;
        wr && (adr == `OFS_SC2 || adr == `OFS_CFG || adr == `OFS_CVH || adr == `OFS_CVL
            || (adr == `OFS_PWR && wd[`PWR_STOP] && csel_r != `CLK_ASYNC))
            |-> ##[1:2] !converter_active;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");
    property p_irq;
        conv_irq |-> $past(ien_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq while disabled");
    property p_gate;
        afe_ctrl.async_clk_en |-> (converter_active || $past(converter_active)
            || $past(converter_active, 2)) or (##[1:2] converter_active);
    endproperty
    a_gate: assert property (p_gate) else $error("async clock on while idle");
    property p_samp;
        samp_r <= 8'h18;
    endproperty
    a_samp: assert property (p_samp) else $error("sample phase too long");
    property p_appr;
        appr_r <= 8'h0F;
    endproperty
    a_appr: assert property (p_appr) else $error("approximation too long");
    property p_excl;
        afe_ctrl.sample_en |-> !afe_ctrl.approx_en;
    endproperty
    a_excl: assert property (p_excl) else $error("input not isolated");
    property p_ready;
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_unmapped;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.paddr > `OFS_PWR
            |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    c_restart: cover property (wr && adr == `OFS_SC1 && converter_active);
    c_irq: cover property (conv_irq);
    c_async: cover property (afe_ctrl.async_clk_en);
endmodule : conv_ctrl_props

// ---- sim/afe_model.sv ----
// Analog inputs and hardware trigger source seen by the block
`timescale 1ns/1ns
module afe_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire conv_ctrl_pkg::afe_ctrl_s afe_ctrl,
    input wire logic trig_req,
    output logic [9:0] afe_result,
    output logic hw_trigger_input
);
    import conv_ctrl_pkg::*;
    logic [1:0] hold_r;
    logic busy;
    // Level valid only near a conversion; toggles otherwise so stale reads show
    assign busy = afe_ctrl.sample_en || afe_ctrl.approx_en;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= 2'h0;
            afe_result <= 10'h000;
        end else begin
            hold_r <= busy ? 2'h3 : hold_r - {1'b0, hold_r != 2'h0};
            afe_result <= (busy || hold_r != 2'h0) ? {afe_ctrl.channel, 5'h0A} : ~afe_result;
        end
    end
    // Trigger edge source, one register from the bench request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) hw_trigger_input <= 1'b0;
        else hw_trigger_input <= trig_req;
    end
endmodule : afe_model

// ---- sim/test_adc_conversion_control.sv ----
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
`include "conv_ctrl_cfg.svh"
module test_adc_conversion_control;
    import conv_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    apb_req_s apb_req = '0;
    apb_rsp_s apb_rsp;
    logic trig_req = 1'b0;
    logic hw_trigger_input;
    logic [9:0] afe_result;
    afe_ctrl_s afe_ctrl;
    logic conv_irq;
    logic converter_active;
    int failures = 0;
    int checks = 0;
    logic [32:0] exp_q[$];
    logic [7:0] lfsr = 8'h53;
    logic [7:0] cfg_t[5] = '{8'h00, 8'h88, 8'h10, 8'h18, 8'h0B};
    int bud_t[5] = '{25, 28, 45, 48, 28};
    logic [11:0] ab_a[5] = '{`OFS_SC2, `OFS_CFG, `OFS_CVH, `OFS_CVL, `OFS_PWR};
    logic [7:0] ab_d[5] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h02};
    logic [4:0] ch;
    logic [9:0] lvl;
    int n;
    int k;
    always #5 clk = ~clk;
    adc_conversion_control u_adc_conversion_control (.clk(clk), .rst_b(rst_b),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .hw_trigger_input(hw_trigger_input),
        .afe_result(afe_result), .afe_ctrl(afe_ctrl), .conv_irq(conv_irq),
        .converter_active(converter_active));
    afe_model u_afe_model (.clk(clk), .rst_b(rst_b), .afe_ctrl(afe_ctrl),
        .trig_req(trig_req), .afe_result(afe_result), .hw_trigger_input(hw_trigger_input));
    // =============================================
    // Tasks
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [32:0] seen, input logic [32:0] expd);
        checks++;
        if (seen !== expd) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expd);
        end
    endtask : check
    // One transfer, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        input logic [32:0] e);
        int t;
        if (!w) exp_q.push_back(e);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (apb_rsp.pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            failures++;
            finish_test();
        end
        apb_req <= '0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {25'h0, d});
    endtask : rd
    function automatic logic sig(input int s);
        return s == 0 ? conv_irq : (s == 1 ? converter_active : afe_ctrl.approx_en);
    endfunction : sig
    task automatic wait_for(input int s, input logic v, output int c);
        c = 0;
        while (sig(s) !== v && c < 700) begin
            @(posedge clk);
            c++;
        end
        if (c >= 700) begin
            failures++;
            finish_test();
        end
    endtask : wait_for
    task automatic pulse();
        trig_req <= 1'b1;
        @(posedge clk);
        trig_req <= 1'b0;
        @(posedge clk);
    endtask : pulse
    // Read answers against the oldest note
    always @(posedge clk) begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
            check({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
        end
    end
    // =============================================
    // Scenarios
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`OFS_SC1, `SC1_RST);
        rd(`OFS_RL, 8'h00);
        apb(1'b0, 12'h040, 8'h00, {1'b1, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            ch = (lfsr[4:0] == `CH_OFF) ? 5'h15 : lfsr[4:0];
            lvl = {ch, 5'h0A};
            wr(`OFS_CFG, cfg_t[i]);
            wr(`OFS_SC1, {3'h2, ch});
            wait_for(0, 1'b1, n);
            check(n <= bud_t[i] + (cfg_t[i][1:0] == 2'h3 ? 503 : 3), 1'b1);
            check(n + 2 >= bud_t[i], 1'b1);
            if (cfg_t[i][3]) rd(`OFS_RH, {6'h0, lvl[9:8]});
            rd(`OFS_RL, cfg_t[i][3] ? lvl[7:0] : lvl[9:2]);
            rd(`OFS_SC1, {3'h2, ch});
        end
        $display("test timing done");
        wr(`OFS_CFG, 8'h08);
        wr(`OFS_SC1, 8'h15);
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b0, n);
        check(conv_irq, 1'b0);
        rd(`OFS_SC1, 8'h95);
        wr(`OFS_SC1, 8'h1F);
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            check(converter_active, 1'b0);
        end
        wr(`OFS_SC2, 8'h40);
        wr(`OFS_SC1, 8'h55);
        check(converter_active, 1'b0);
        pulse();
        wait_for(2, 1'b1, n);
        pulse();
        wait_for(0, 1'b1, n);
        rd(`OFS_RH, 8'h02);
        rd(`OFS_RL, 8'hAA);
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            check(converter_active, 1'b0);
        end
        $display("test trigger done");
        wr(`OFS_SC2, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_SC1, 8'h43);
            wait_for(2, 1'b1, n);
            wr(ab_a[i], ab_d[i]);
            wait_for(1, 1'b0, n);
            check(n <= 3, 1'b1);
        end
        wr(`OFS_PWR, 8'h00);
        rd(`OFS_SC1, 8'h43);
        rd(`OFS_RH, 8'h02);
        rd(`OFS_RL, 8'hAA);
        wr(`OFS_PWR, 8'h01);
        wr(`OFS_SC1, 8'h55);
        wait_for(2, 1'b1, n);
        wr(`OFS_SC1, 8'h43);
        wait_for(0, 1'b1, n);
        check(n + 2 >= 28, 1'b1);
        rd(`OFS_RH, 8'h00);
        rd(`OFS_RL, 8'h6A);
        wr(`OFS_PWR, 8'h00);
        $display("test abort done");
        wr(`OFS_SC1, 8'h55);
        wait_for(2, 1'b1, n);
        rd(`OFS_RH, 8'h00);
        n = 0;
        for (k = 0; k < 80; k++) begin
            @(posedge clk);
            n += (afe_ctrl.sample_en === 1'b1 && afe_ctrl.approx_en === 1'b0 && k > 5);
        end
        check(conv_irq, 1'b0);
        check(n >= 4, 1'b1);
        rd(`OFS_RL, 8'h6A);
        wait_for(0, 1'b1, n);
        rd(`OFS_RH, 8'h02);
        rd(`OFS_RL, 8'hAA);
        $display("test blocking done");
        wr(`OFS_CVH, 8'h01);
        wr(`OFS_CVL, 8'h00);
        wr(`OFS_SC2, 8'h30);
        wr(`OFS_SC1, 8'h55);
        wait_for(0, 1'b1, n);
        rd(`OFS_RH, 8'h01);
        rd(`OFS_RL, 8'hAA);
        rd(`OFS_RH, 8'h01);
        wr(`OFS_SC2, 8'h20);
        wr(`OFS_SC1, 8'h55);
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b0, n);
        check(conv_irq, 1'b0);
        rd(`OFS_SC1, 8'h55);
        rd(`OFS_RL, 8'hAA);
        $display("test compare done");
        wr(`OFS_SC2, 8'h00);
        wr(`OFS_SC1, 8'h75);
        wait_for(0, 1'b1, n);
        rd(`OFS_RH, 8'h02);
        rd(`OFS_RL, 8'hAA);
        wait_for(0, 1'b0, n);
        wait_for(0, 1'b1, n);
        check(n + 7 <= 20, 1'b1);
        check(converter_active, 1'b1);
        wr(`OFS_SC1, 8'h1F);
        wait_for(1, 1'b0, n);
        check(n <= 3, 1'b1);
        $display("test continuous done");
        finish_test();
    end
endmodule : test_adc_conversion_control
bind adc_conversion_control conv_ctrl_props u_conv_ctrl_props (.clk(clk), .rst_b(rst_b),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .hw_trigger_input(hw_trigger_input),
    .afe_result(afe_result), .afe_ctrl(afe_ctrl), .conv_irq(conv_irq),
    .converter_active(converter_active));
